// ### common/lbr_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef LBR_MAP_SVH
`define LBR_MAP_SVH

// register offsets on the plain register port
`define LBR_ADDR_W          3
`define LBR_OFF_CTRL0       3'h0
`define LBR_OFF_CTRL1       3'h1
`define LBR_OFF_CTRL2       3'h2
`define LBR_OFF_POWER       3'h3
`define LBR_OFF_STATUS      3'h4

// control register 0 fields
`define LBR_C0_WAVE_TYPE    7
`define LBR_C0_RES_HI       3
`define LBR_C0_RES_LO       1
`define LBR_C0_ENABLE       0
// control register 1 fields
`define LBR_C1_QCT_HI       7
`define LBR_C1_QCT_LO       5
`define LBR_C1_TOP_HI       3
`define LBR_C1_TOP_LO       0
// control register 2 fields
`define LBR_C2_DUTY_HI      2
`define LBR_C2_DUTY_LO      1
`define LBR_C2_BIAS         0
// power register fields
`define LBR_PW_SRC          3
`define LBR_PW_LVL_HI       1
`define LBR_PW_LVL_LO       0
// status register fields
`define LBR_ST_DRV_RESET    0
`define LBR_ST_FLOATING     1
`define LBR_ST_QC_WINDOW    2
`define LBR_ST_POLARITY     3
`define LBR_ST_SLOT_HI      6
`define LBR_ST_SLOT_LO      4

// reset values and the unimplemented duty code
`define LBR_RST_BYTE        8'h00
`define LBR_RST_DUTY        2'h0
`define LBR_DUTY_BAD        2'h3

// low bias resistor code on the ladder select output, and top level base and full values
`define LBR_RES_LOW         2'h2
`define LBR_TOP_BASE        5'h08
`define LBR_TOP_FULL        5'h10

// sub clock divide and timing figures
`define LBR_SUB_DIV         8
`define LBR_CLK_PERIOD_NS   20
`define LBR_RSTD_NS         25000
`define LBR_SST_NS          16000

`endif

// ### common/lbr_pkg.sv
// types shared by the bias, reset and waveform control block
`default_nettype none
package lbr_pkg;

  // output mode of the common and segment drivers
  typedef enum logic [2:0] {
    lbr_float = 3'h1,
    lbr_low   = 3'h2,
    lbr_run   = 3'h4
  } lbr_mode_t;

  // ladder tap count above ground, in steps of top level / bias divisor
  typedef logic [2:0] lbr_level_t;

endpackage : lbr_pkg
`default_nettype wire

// ### common/lbr_sync_if.sv
// carrier for the filtered outside inputs between synchroniser and core
`default_nettype none
interface lbr_sync_if #(parameter int unsigned W = 3);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : lbr_sync_if
`default_nettype wire

// ### hdl/lbr_ctrl.sv
// bias, reset gating and common/segment waveform control for the panel
`include "lbr_map.svh"
`default_nettype none

// Notes on behaviour
// RULE_01 - source bit picks pump, else pin, pump off
// RULE_02 - two-bit field picks four pump levels
// RULE_03 - third bias drives four levels
// RULE_04 - quarter bias drives five levels
// RULE_05 - four-bit field sets top level fraction
// RULE_06 - software picks quarter bias for eight commons
// RULE_07 - three-bit field picks ladder resistance
// RULE_08 - ladder current path off while disabled
// RULE_09 - quick-charge window set by three-bit field
// RULE_10 - driver reset is disable or sleep
// RULE_11 - sleep resets driver despite enable set
// RULE_12 - chip reset resets driver, outputs float
// RULE_13 - float lasts debounce plus startup delay
// RULE_14 - disabled or sleeping: outputs held low
// RULE_15 - idle or sleep watchdog reset not chip reset
// RULE_16 - duty sets common count and frame slots
// RULE_17 - type bit picks waveform, second is slower
// RULE_18 - pixel voltage averages to zero DC
// RULE_19 - window lasts code plus one sub periods
// RULE_20 - codes four up enable quick charge
// RULE_21 - display clock is sub clock over eight
// RULE_22 - duty codes give four, six, eight commons
// RULE_23 - type one flips per slot, two per frame
// RULE_24 - active slot drives extremes, else mid levels
module lbr_ctrl #(
  parameter int unsigned NSEG    = 40,
  parameter int unsigned NCOM    = 8,
  parameter int unsigned RSTD_NS = `LBR_RSTD_NS,
  parameter int unsigned SST_NS  = `LBR_SST_NS
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [`LBR_ADDR_W-1:0]      reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        sub_clk_pin,
  input  wire logic                        chip_rst_pin,
  input  wire logic                        wdt_rst_pin,
  input  wire logic                        sleep,
  input  wire logic                        idle,
  input  wire logic [NSEG-1:0]             seg_pixel,
  output logic      [2:0]                  slot_index,
  output logic      [NCOM*3-1:0]           com_level,
  output logic      [NCOM-1:0]             com_oe,
  output logic      [NSEG*3-1:0]           seg_level,
  output logic      [NSEG-1:0]             seg_oe,
  output logic                             pump_en,
  output logic      [1:0]                  pump_level_sel,
  output logic                             supply_from_pin,
  output logic      [4:0]                  top_level_num,
  output logic                             quarter_bias,
  output logic                             ladder_on,
  output logic      [1:0]                  res_code
);

  // least time rounds up, never below one cycle
  localparam int unsigned FLOAT_NS  = RSTD_NS + SST_NS;
  localparam int unsigned FLOAT_RAW =
    (FLOAT_NS + `LBR_CLK_PERIOD_NS - 1) / `LBR_CLK_PERIOD_NS;
  localparam int unsigned FLOAT_CYC = (FLOAT_RAW < 1) ? 1 : FLOAT_RAW;
  localparam int unsigned FCW       = $clog2(FLOAT_CYC + 1);

  if (NCOM != 8) begin : g_bad_com
    $error("lbr_ctrl serves exactly eight common lines");
  end
  if (NSEG < 1 || NSEG > 64) begin : g_bad_seg
    $error("lbr_ctrl serves 1 to 64 segment lines");
  end

  // lane 0 sub clock, lane 1 chip reset, lane 2 watchdog reset
  lbr_sync_if #(.W(3)) sy ();
  lbr_sync #(.W(3)) u_sync (
    .clk  (clk),
    .srst (srst),
    .raw  ({wdt_rst_pin, chip_rst_pin, sub_clk_pin}),
    .sy   (sy)
  );

  logic sub_tick;
  logic chip_rst;
  assign sub_tick = sy.rise[0];
  // watchdog reset while idle or asleep leaves the display alone [RULE_15]
  assign chip_rst = sy.level[1] | (sy.level[2] & ~(idle | sleep));

  // control fields
  logic       wave_type_reg;
  logic [2:0] bias_resistor_sel_reg;
  logic       display_enable_reg;
  logic [2:0] quick_charge_time_sel_reg;
  logic [3:0] top_bias_level_sel_reg;
  logic [1:0] duty_sel_reg;
  logic       bias_quarter_reg;
  logic       panel_power_source_sel_reg;
  logic [1:0] pump_level_sel_reg;

  // chip reset clears control just as a full reset does
  always_ff @(posedge clk) begin
    if (srst || chip_rst) begin
      wave_type_reg              <= 1'b0;
      bias_resistor_sel_reg      <= 3'h0;
      display_enable_reg         <= 1'b0;
      quick_charge_time_sel_reg  <= 3'h0;
      top_bias_level_sel_reg     <= 4'h0;
      duty_sel_reg               <= `LBR_RST_DUTY;
      bias_quarter_reg           <= 1'b0;
      panel_power_source_sel_reg <= 1'b0;
      pump_level_sel_reg         <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `LBR_OFF_CTRL0: begin
          wave_type_reg         <= reg_wdata[`LBR_C0_WAVE_TYPE];
          bias_resistor_sel_reg <=
            reg_wdata[`LBR_C0_RES_HI:`LBR_C0_RES_LO];
          display_enable_reg    <= reg_wdata[`LBR_C0_ENABLE];
        end
        `LBR_OFF_CTRL1: begin
          quick_charge_time_sel_reg <=
            reg_wdata[`LBR_C1_QCT_HI:`LBR_C1_QCT_LO];
          top_bias_level_sel_reg    <=
            reg_wdata[`LBR_C1_TOP_HI:`LBR_C1_TOP_LO];
        end
        `LBR_OFF_CTRL2: begin
          // the unimplemented duty code keeps the previous duty [RULE_22]
          if (reg_wdata[`LBR_C2_DUTY_HI:`LBR_C2_DUTY_LO] != `LBR_DUTY_BAD)
          begin
            duty_sel_reg <= reg_wdata[`LBR_C2_DUTY_HI:`LBR_C2_DUTY_LO];
          end
          bias_quarter_reg <= reg_wdata[`LBR_C2_BIAS];
        end
        `LBR_OFF_POWER: begin
          panel_power_source_sel_reg <= reg_wdata[`LBR_PW_SRC];
          pump_level_sel_reg <= reg_wdata[`LBR_PW_LVL_HI:`LBR_PW_LVL_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // floating hold: reloaded while chip reset stands, runs out after it
  logic [FCW-1:0] float_cnt_reg;
  logic           floating;
  always_ff @(posedge clk) begin
    if (srst || chip_rst) begin
      float_cnt_reg <= FCW'(FLOAT_CYC); // [RULE_13]
    end else if (float_cnt_reg != '0) begin
      float_cnt_reg <= float_cnt_reg - FCW'(1);
    end
  end
  assign floating = chip_rst || (float_cnt_reg != '0); // [RULE_12]

  // driver reset: disabled, floating or sleeping, whatever the enable says in sleep
  logic drv_reset;
  assign drv_reset = ~display_enable_reg | floating // [RULE_10]
    | sleep; // [RULE_11]

  // output mode machine
  lbr_pkg::lbr_mode_t mode_reg;
  lbr_pkg::lbr_mode_t mode_next;
  always_comb begin
    case (mode_reg)
      lbr_pkg::lbr_float, lbr_pkg::lbr_low, lbr_pkg::lbr_run: begin
        if (floating) begin
          mode_next = lbr_pkg::lbr_float; // [RULE_12]
        end else if (drv_reset) begin
          mode_next = lbr_pkg::lbr_low; // [RULE_14]
        end else begin
          mode_next = lbr_pkg::lbr_run;
        end
      end
      default: mode_next = lbr_pkg::lbr_float;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= lbr_pkg::lbr_float;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // index of the last common slot for the chosen duty
  logic [2:0] last_slot;
  always_comb begin
    case (duty_sel_reg)
      2'h0:    last_slot = 3'h3; // [RULE_16] [RULE_22]
      2'h1:    last_slot = 3'h5;
      default: last_slot = 3'h7;
    endcase
  end

  // display clock: eight sub clock periods per tick
  logic [2:0] div_reg;
  logic       lcd_tick;
  assign lcd_tick = sub_tick && (div_reg == 3'(`LBR_SUB_DIV - 1)); // [RULE_21]

  // slot sequencing, held in reset while the driver is reset
  logic [2:0] slot_reg;
  logic       half_reg;
  logic       frame_pol_reg;
  logic       pol;
  always_ff @(posedge clk) begin
    if (srst || drv_reset) begin
      div_reg       <= 3'h0;
      slot_reg      <= 3'h0;
      half_reg      <= 1'b0;
      frame_pol_reg <= 1'b0;
    end else begin
      if (sub_tick) begin
        div_reg <= div_reg + 3'h1;
      end
      if (lcd_tick) begin
        // type A splits each slot in two halves of opposite polarity
        if (!wave_type_reg && !half_reg) begin
          half_reg <= 1'b1; // [RULE_23]
        end else begin
          half_reg <= 1'b0;
          if (slot_reg >= last_slot) begin
            slot_reg      <= 3'h0;
            frame_pol_reg <= ~frame_pol_reg; // [RULE_23]
          end else begin
            slot_reg <= slot_reg + 3'h1;
          end
        end
      end
    end
  end
  // type B flips only per frame, so its drive runs at lower frequency
  assign pol = wave_type_reg ? frame_pol_reg : half_reg; // [RULE_17]

  // quick-charge window counted in sub periods from each phase start
  logic [3:0] qc_cnt_reg;
  logic       qc_window;
  always_ff @(posedge clk) begin
    if (srst || drv_reset || lcd_tick) begin
      qc_cnt_reg <= 4'h0;
    end else if (sub_tick && qc_cnt_reg != 4'h8) begin
      qc_cnt_reg <= qc_cnt_reg + 4'h1;
    end
  end
  // count 0..n inclusive gives n plus one periods [RULE_09] [RULE_19]
  assign qc_window = (qc_cnt_reg <= {1'b0, quick_charge_time_sel_reg});

  // ladder resistor: low value in the window, high value after it
  logic [1:0] res_next;
  always_comb begin
    if (!bias_resistor_sel_reg[2]) begin
      res_next = bias_resistor_sel_reg[1:0]; // [RULE_07]
    end else if (qc_window) begin
      res_next = `LBR_RES_LOW; // [RULE_20]
    end else if (bias_resistor_sel_reg[1]) begin
      res_next = 2'h3;
    end else begin
      res_next = {1'b0, bias_resistor_sel_reg[0]};
    end
  end

  // mirrored taps k and top-k keep every pixel's average at zero
  function automatic lbr_pkg::lbr_level_t com_tap(
    input logic on,
    input logic p,
    input logic quarter
  );
    lbr_pkg::lbr_level_t den;
    den = quarter ? 3'h4 : 3'h3; // [RULE_03] [RULE_04]
    if (on) begin
      com_tap = p ? den : 3'h0; // [RULE_24]
    end else begin
      com_tap = p ? 3'h1 : den - 3'h1;
    end
  endfunction : com_tap

  function automatic lbr_pkg::lbr_level_t seg_tap(
    input logic on,
    input logic p,
    input logic quarter
  );
    lbr_pkg::lbr_level_t den;
    den = quarter ? 3'h4 : 3'h3;
    if (on) begin
      seg_tap = p ? 3'h0 : den; // [RULE_24]
    end else begin
      seg_tap = p ? 3'h2 : den - 3'h2;
    end
  endfunction : seg_tap

  logic run;
  assign run = (mode_next == lbr_pkg::lbr_run);

  // common drivers: float, low, or bias taps in run
  for (genvar i = 0; i < NCOM; i++) begin : g_com
    always_ff @(posedge clk) begin
      if (srst || !run) begin
        com_level[i*3 +: 3] <= 3'h0; // [RULE_14]
        com_oe[i] <= (mode_next == lbr_pkg::lbr_low); // [RULE_12]
      end else begin
        com_level[i*3 +: 3] <=
          com_tap(slot_reg == 3'(i), pol, bias_quarter_reg); // [RULE_18]
        com_oe[i] <= (3'(i) <= last_slot); // [RULE_16]
      end
    end
  end

  // segment drivers follow the pixel bit of the active slot
  for (genvar j = 0; j < NSEG; j++) begin : g_seg
    always_ff @(posedge clk) begin
      if (srst || !run) begin
        seg_level[j*3 +: 3] <= 3'h0; // [RULE_14]
        seg_oe[j] <= (mode_next == lbr_pkg::lbr_low); // [RULE_12]
      end else begin
        seg_level[j*3 +: 3] <=
          seg_tap(seg_pixel[j], pol, bias_quarter_reg); // [RULE_18]
        seg_oe[j] <= 1'b1;
      end
    end
  end

  // supply, pump and ladder controls
  always_ff @(posedge clk) begin
    if (srst) begin
      pump_en         <= 1'b0;
      pump_level_sel  <= 2'h0;
      supply_from_pin <= 1'b1;
      top_level_num   <= `LBR_TOP_BASE;
      quarter_bias    <= 1'b0;
      ladder_on       <= 1'b0;
      res_code        <= 2'h0;
      slot_index      <= 3'h0;
    end else begin
      pump_en         <= panel_power_source_sel_reg; // [RULE_01]
      supply_from_pin <= ~panel_power_source_sel_reg; // [RULE_01]
      pump_level_sel  <= pump_level_sel_reg; // [RULE_02]
      // top level in sixteenths of the supply
      top_level_num   <= top_bias_level_sel_reg[3] ? `LBR_TOP_FULL :
        (`LBR_TOP_BASE + {2'h0, top_bias_level_sel_reg[2:0]}); // [RULE_05]
      quarter_bias    <= bias_quarter_reg; // [RULE_04]
      ladder_on       <= run; // [RULE_08]
      res_code        <= res_next; // [RULE_07]
      slot_index      <= slot_reg;
    end
  end

  // read data stands in the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= `LBR_RST_BYTE;
    end else begin
      case (reg_addr)
        `LBR_OFF_CTRL0: reg_rdata <= {wave_type_reg, 3'h0,
          bias_resistor_sel_reg, display_enable_reg};
        `LBR_OFF_CTRL1: reg_rdata <= {quick_charge_time_sel_reg, 1'b0,
          top_bias_level_sel_reg};
        `LBR_OFF_CTRL2: reg_rdata <= {5'h00, duty_sel_reg,
          bias_quarter_reg};
        `LBR_OFF_POWER: reg_rdata <= {4'h0, panel_power_source_sel_reg,
          1'b0, pump_level_sel_reg};
        `LBR_OFF_STATUS: reg_rdata <= {1'b0, slot_reg, pol, qc_window,
          floating, drv_reset};
        default: reg_rdata <= `LBR_RST_BYTE;
      endcase
    end
  end

endmodule : lbr_ctrl
`default_nettype wire

// ### hdl/lbr_sync.sv
// three-flop input synchroniser with agreement filter, one lane per bit
`default_nettype none
module lbr_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire logic [W-1:0] raw,
  lbr_sync_if.src        sy
);

  if (W < 1) begin : g_bad_width
    $error("lbr_sync needs at least one lane");
  end

  for (genvar i = 0; i < W; i++) begin : g_lane
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic filt_reg;
    logic rise_reg;

    // first flop feeds only the second
    always_ff @(posedge clk) begin
      if (srst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
      end else begin
        s1_reg <= raw[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end

    // a change counts only once the second and third flop agree
    always_ff @(posedge clk) begin
      if (srst) begin
        filt_reg <= 1'b0;
        rise_reg <= 1'b0;
      end else begin
        if (s2_reg == s3_reg) begin
          filt_reg <= s3_reg;
        end
        rise_reg <= (s2_reg == s3_reg) && s3_reg && !filt_reg;
      end
    end

    assign sy.level[i] = filt_reg;
    assign sy.rise[i]  = rise_reg;
  end

endmodule : lbr_sync
`default_nettype wire

// ### test/lbr_ctrl_asserts.sv
// concurrent checks on the panel control ports
`include "lbr_map.svh"
`default_nettype none
module lbr_ctrl_asserts #(
  parameter int unsigned NSEG = 40,
  parameter int unsigned NCOM = 8
) (
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic [`LBR_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   sub_clk_pin,
  input wire logic                   chip_rst_pin,
  input wire logic                   wdt_rst_pin,
  input wire logic                   sleep,
  input wire logic [2:0]             slot_index,
  input wire logic [NCOM*3-1:0]      com_level,
  input wire logic [NCOM-1:0]        com_oe,
  input wire logic [NSEG*3-1:0]      seg_level,
  input wire logic [NSEG-1:0]        seg_oe,
  input wire logic                   pump_en,
  input wire logic [1:0]             pump_level_sel,
  input wire logic                   supply_from_pin,
  input wire logic [4:0]             top_level_num,
  input wire logic                   ladder_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // writes count once the chip reset filter has drained
  sequence s_calm;
    (!chip_rst_pin)[*8];
  endsequence
  sequence s_chip;
    chip_rst_pin[*8];
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_rd_unmapped;
    reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00;
  endproperty
  property p_power;
    logic [7:0] d;
    (s_calm ##0 (reg_wr && reg_addr == `LBR_OFF_POWER, d = reg_wdata)) |->
      ##2 (pump_en == d[3] && supply_from_pin == !d[3] &&
           pump_level_sel == d[1:0]);
  endproperty
  property p_top;
    logic [7:0] d;
    (s_calm ##0 (reg_wr && reg_addr == `LBR_OFF_CTRL1, d = reg_wdata)) |->
      ##2 top_level_num == (d[3] ? 5'h10 : {2'h1, d[2:0]});
  endproperty
  property p_sleep_low;
    sleep[*4] |-> !ladder_on && com_level == '0 && seg_level == '0;
  endproperty
  property p_sleep_oe;
    sleep[*4] |-> (com_oe == '0 && seg_oe == '0) || (&com_oe && &seg_oe);
  endproperty
  property p_float;
    s_chip |-> com_oe == '0 && seg_oe == '0 && !ladder_on;
  endproperty
  property p_float_hold;
    s_chip ##1 !chip_rst_pin |-> (com_oe == '0 && seg_oe == '0)[*8];
  endproperty
  // slot moves only on ticks
  property p_slot_hold;
    ($stable(sub_clk_pin) && $stable(sleep) && !reg_wr && !chip_rst_pin &&
     !wdt_rst_pin)[*8] |=> $stable(slot_index);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero when idle");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  a_power: assert property (p_power)
    else $error("power controls wrong");
  a_top: assert property (p_top)
    else $error("top level wrong");
  a_sleep_low: assert property (p_sleep_low)
    else $error("sleep not low");
  a_sleep_oe: assert property (p_sleep_oe)
    else $error("sleep enables wrong");
  a_float: assert property (p_float)
    else $error("driven in chip reset");
  a_float_hold: assert property (p_float_hold)
    else $error("float ended early");
  a_slot_hold: assert property (p_slot_hold)
    else $error("slot moved while idle");
endmodule : lbr_ctrl_asserts

bind lbr_ctrl lbr_ctrl_asserts #(.NSEG(NSEG), .NCOM(NCOM)) u_asserts (
  .clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sub_clk_pin, .chip_rst_pin, .wdt_rst_pin, .sleep, .slot_index,
  .com_level, .com_oe, .seg_level, .seg_oe, .pump_en, .pump_level_sel,
  .supply_from_pin, .top_level_num, .ladder_on);
`default_nettype wire

// ### test/lbr_glass.sv
// passive panel model: sums common minus segment drive per pixel
`default_nettype none
module lbr_glass #(
  parameter int unsigned NSEG = 8,
  parameter int unsigned NCOM = 8
) (
  input  wire logic              clk,
  input  wire logic              clr,
  input  wire logic [NCOM*3-1:0] com_level,
  input  wire logic [NCOM-1:0]   com_oe,
  input  wire logic [NSEG*3-1:0] seg_level,
  input  wire logic [NSEG-1:0]   seg_oe,
  output var  int                dc_max
);
  timeunit 1ns;
  timeprecision 1ns;
  int acc [NCOM][NSEG];
  int a;
  // sampled mid-cycle, off the launch edge
  always @(negedge clk) begin
    dc_max = 0;
    for (int c = 0; c < NCOM; c++) begin
      for (int s = 0; s < NSEG; s++) begin
        if (clr) begin
          acc[c][s] = 0;
        end else if (com_oe[c] && seg_oe[s]) begin
          acc[c][s] += com_level[c*3 +: 3] - seg_level[s*3 +: 3];
        end
        a = acc[c][s] < 0 ? -acc[c][s] : acc[c][s];
        if (a > dc_max) begin
          dc_max = a;
        end
      end
    end
  end
endmodule : lbr_glass
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the panel control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NS = 8;
  localparam int SUBH = 5;
  localparam int FLT = (200 + 100) / 20;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, sub_clk_pin = 0;
  logic chip_rst_pin = 0, wdt_rst_pin = 0, sleep = 0, idle = 0, clr = 0;
  logic [2:0] reg_addr = 0, slot_index;
  logic [7:0] reg_wdata = 0, reg_rdata, seg_pixel = 0, com_oe, seg_oe;
  logic [23:0] com_level, seg_level;
  logic [1:0] pump_level_sel, res_code;
  logic [4:0] top_level_num;
  logic pump_en, supply_from_pin, quarter_bias, ladder_on;
  logic [7:0] m [4], pix [8], rd_val, d;
  logic [2:0] lv;
  int fails = 0, cmp_count = 0, seed = 86, sub_cnt = 0, dc_max;
  int n, mx, ch, ml, fl, cnt [6];
  lbr_ctrl #(.NSEG(NS), .NCOM(8), .RSTD_NS(200), .SST_NS(100)) u_dut (
    .clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sub_clk_pin, .chip_rst_pin, .wdt_rst_pin, .sleep, .idle, .seg_pixel,
    .slot_index, .com_level, .com_oe, .seg_level, .seg_oe, .pump_en,
    .pump_level_sel, .supply_from_pin, .top_level_num, .quarter_bias,
    .ladder_on, .res_code);
  lbr_glass #(.NSEG(NS), .NCOM(8)) u_glass (
    .clk, .clr, .com_level, .com_oe, .seg_level, .seg_oe, .dc_max);
  initial forever #10 clk = ~clk;
  // sub clock every ten cycles, held in sleep; pixels track the slot
  always @(posedge clk) begin
    sub_cnt <= (sub_cnt == SUBH - 1) ? 0 : sub_cnt + 1;
    if (sub_cnt == SUBH - 1 && !sleep) begin
      sub_clk_pin <= !sub_clk_pin;
    end
    seg_pixel <= pix[slot_index];
  end
  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    cmp_count++;
    if (rd_val !== e) begin
      fails++;
      $display("CHECK FAILED reg%0d exp=%0h got=%0h", a, e, rd_val);
    end
  endtask : chk_rd
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
    if (a == 3'h2 && v[2:1] == 2'h3) begin
      v[2:1] = m[2][2:1];
    end
    if (a < 3'h4) begin
      m[a] = v & (a == 0 ? 8'h8F : a == 1 ? 8'hEF : a == 2 ? 8'h07 : 8'h0B);
    end
  endtask : wr
  task automatic rd(input logic [2:0] a);
    bus(1'b0, a, 8'h00);
    if (a != 3'h4) begin
      chk_rd(a, a < 3'h4 ? m[a] : 8'h00);
    end
  endtask : rd
  // quick charge may own code two
  task automatic chk_out;
    logic [2:0] c;
    logic [1:0] r;
    c = m[0][3:1];
    @(posedge clk);
    #1;
    r = c < 3'h4 ? c[1:0] : c == 3'h4 ? 2'h0 : c == 3'h5 ? 2'h1 : 2'h3;
    r = (c[2] && res_code === 2'h2) ? 2'h2 : r;
    chk_val("pump_en", m[3][3], pump_en);
    chk_val("from_pin", !m[3][3], supply_from_pin);
    chk_val("pump_lvl", m[3][1:0], pump_level_sel);
    chk_val("top", m[1][3] ? 16 : 8 + m[1][2:0], top_level_num);
    chk_val("quarter", m[2][0], quarter_bias);
    chk_val("res", r, res_code);
    chk_val("ladder", m[0][0], ladder_on);
  endtask : chk_out
  task automatic float_len;
    fl = 0;
    while (com_oe[0] !== 1'b1 && fl < 100) begin
      @(posedge clk);
      #1 fl++;
    end
  endtask : float_len
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #(20 * 60000);
    fails++;
    end_sim;
  end
  initial begin
    m = '{default: 8'h00};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    float_len;
    chk_val("srst_float", 1, fl >= FLT);
    chk_val("off_low", 0, com_level);
    @(posedge clk);
    rd(3'h4);
    chk_val("drv_reset", 1, rd_val[0]);
    for (int i = 0; i < 24; i++) begin
      n = $unsigned($random(seed)) % 4;
      d = 8'($random(seed));
      if (n == 2 && d[2:1] == 2'h3) begin
        d[0] = m[2][0];
      end
      wr(3'(n), d);
      chk_out;
    end
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
    end
    // two whole periods, so pixel DC cancels
    for (int t = 0; t < 2; t++) begin
      for (int k = 0; k < 3; k++) begin
        n = 4 + 2 * k;
        foreach (pix[j]) pix[j] = 8'($random(seed));
        wr(3'h2, {5'h00, 2'(k), k == 2 || 1'($random(seed))});
        wr(3'h0, {1'(t), 7'h01});
        repeat (200) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        mx = 0;
        ch = 0;
        ml = 0;
        repeat (320 * n) begin
          @(posedge clk);
          #1;
          mx = slot_index > mx ? slot_index : mx;
          ch += (com_level[2:0] !== lv);
          lv = com_level[2:0];
          ml = com_level[2:0] > ml ? com_level[2:0] : ml;
        end
        chk_val("slots", n - 1, mx);
        chk_val("com_oe", (1 << n) - 1, com_oe);
        chk_val("dc", 0, dc_max);
        chk_val("extreme", m[2][0] ? 4 : 3, ml);
        cnt[t*3+k] = ch;
      end
    end
    for (int k = 0; k < 3; k++) begin
      chk_val("slower", 1, cnt[k] > cnt[3+k]);
    end
    for (int q = 0; q < 8; q += 6) begin
      wr(3'h1, {3'(q), 5'h00});
      wr(3'h0, 8'h09);
      #1 fl = 0;
      while (res_code === 2'h2 && fl < 400) begin
        @(posedge clk);
        #1 fl++;
      end
      while (res_code !== 2'h2 && fl < 800) begin
        @(posedge clk);
        #1 fl++;
      end
      n = 0;
      while (res_code === 2'h2 && n < 400) begin
        @(posedge clk);
        #1 n++;
      end
      chk_val("qc_len", (q + 1) * 2 * SUBH, n);
      chk_val("qc_rest", 0, res_code);
    end
    @(posedge clk);
    idle <= 1'b1;
    wdt_rst_pin <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk_val("idle_wdt", 1, com_oe[0]);
    @(posedge clk);
    {sleep, wdt_rst_pin} <= 2'h2;
    repeat (10) @(posedge clk);
    #1 chk_val("sleep_lad", 0, ladder_on);
    chk_val("sleep_oe", 8'hFF, com_oe);
    chk_val("sleep_lvl", 0, com_level);
    @(posedge clk);
    {sleep, idle, wdt_rst_pin} <= 3'h0;
    repeat (10) @(posedge clk);
    #1 chk_val("wake", 1, ladder_on);
    @(posedge clk);
    chip_rst_pin <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk_val("chip_oe", 0, {com_oe, seg_oe});
    @(posedge clk);
    chip_rst_pin <= 1'b0;
    float_len;
    chk_val("chip_float", 1, fl >= FLT);
    m = '{default: 8'h00};
    @(posedge clk);
    rd(3'h0);
    end_sim;
  end
endmodule : testbench
`default_nettype wire
